// ### hdl/twi_cfg_slave.sv
// Two-wire slave configuration port with identification, lock and revision registers.
`timescale 1ns/1ps
`default_nettype none
module twi_cfg_slave
   import twi_cfg_pkg::*;
(
   // Clock, reset, enable.
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Link.
   twi_link_if.slave       link,
   // Address strap and device status.
   input  wire logic [1:0] address_strap_pin,
   input  wire logic       reboot_busy,
   input  wire logic       eeprom_busy,
   input  wire logic       fault_logged,
   // Status out.
   output logic            bus_busy,
   output logic [7:0]      user_id,
   output logic [1:0]      lock_flags
);
   import twi_cfg_pkg::*;

   typedef enum logic [4:0] {
      st_idle = 5'b00001,
      st_addr = 5'b00010,
      st_ptr  = 5'b00100,
      st_wdat = 5'b01000,
      st_rdat = 5'b10000
   } phase_e;

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic       scl_d;
      logic       sda_d;
      logic [1:0] strap_m;
      logic [1:0] strap;
      phase_e     phase;
      logic [3:0] bitn;
      logic [7:0] shift;
      logic       ack;
      logic       rd;
      logic [7:0] ptr;
      logic [7:0] uid;
      logic [1:0] lock;
      logic       busy;
      logic       drive_low;
   } state_s;

   state_s cur_r, cur_nxt;

   function automatic logic legal_addr(input logic [7:0] a);
      legal_addr = (a == reg_user_id_off) || (a == reg_lock_off) || (a == reg_revision_off);
   endfunction : legal_addr

   function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] u, input logic [1:0] l);
      unique case (a)
         reg_user_id_off : read_reg = u;
         reg_lock_off    : read_reg = {6'h00, l};
         default         : read_reg = {5'h00, revision_code};
      endcase
   endfunction : read_reg

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl      = cur_r.scl_s[1];
   assign sda      = cur_r.sda_s[1];
   assign scl_rise = scl && !cur_r.scl_d;
   assign scl_fall = !scl && cur_r.scl_d;
   assign start_c  = scl && cur_r.scl_d && cur_r.sda_d && !sda;
   assign stop_c   = scl && cur_r.scl_d && !cur_r.sda_d && sda;

   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.scl_s = {cur_r.scl_s[0], link.scl_line};
      cur_nxt.sda_s = {cur_r.sda_s[0], link.sda_line};
      cur_nxt.scl_d = scl;
      cur_nxt.sda_d = sda;
      // The strap is a pin: it is synchronised, then held frozen for the whole of a transfer.
      cur_nxt.strap_m = address_strap_pin;
      if (cur_r.phase == st_idle && !cur_r.busy) begin
         cur_nxt.strap = cur_r.strap_m;
      end
      if (start_c) begin
         cur_nxt.phase = st_addr;
         // The clock fall that closes the condition wraps the count to zero before the first bit.
         cur_nxt.bitn = 4'hF;
         cur_nxt.busy = 1'b1;
         cur_nxt.drive_low = 1'b0;
      end else if (stop_c) begin
         cur_nxt.phase = st_idle;
         cur_nxt.busy = 1'b0;
         cur_nxt.drive_low = 1'b0;
      end else if (cur_r.phase != st_idle) begin
         if (scl_rise && cur_r.bitn < bits_per_word) begin
            cur_nxt.shift = {cur_r.shift[6:0], sda};
         end
         if (scl_rise && cur_r.bitn == bits_per_word && cur_r.phase == st_rdat && sda) begin
            cur_nxt.phase = st_idle;
         end
         if (scl_fall) begin
            cur_nxt.bitn = (cur_r.bitn == bits_per_word) ? 4'h0 : cur_r.bitn + 4'h1;
            cur_nxt.drive_low = 1'b0;
            if (cur_r.bitn == bits_per_word - 4'h1) begin
               unique case (cur_r.phase)
                  st_addr : begin
                     // The address bit below the strap bits is a don't-care.
                     cur_nxt.ack = cur_r.shift[7:4] == addr_upper && cur_r.shift[3:2] == cur_r.strap;
                     cur_nxt.rd  = cur_r.shift[0];
                  end
                  st_ptr  : cur_nxt.ack = legal_addr(cur_r.shift) && !reboot_busy && !eeprom_busy;
                  st_wdat : cur_nxt.ack = 1'b1;
                  default : cur_nxt.ack = 1'b0;
               endcase
               cur_nxt.drive_low = cur_r.phase != st_rdat && cur_nxt.ack;
            end else if (cur_r.bitn == bits_per_word) begin
               unique case (cur_r.phase)
                  st_addr : begin
                     if (!cur_r.ack) begin
                        cur_nxt.phase = st_idle;
                     end else if (cur_r.rd) begin
                        cur_nxt.phase = st_rdat;
                     end else begin
                        cur_nxt.phase = st_ptr;
                     end
                  end
                  st_ptr  : begin
                     if (cur_r.ack) begin
                        cur_nxt.ptr = cur_r.shift;
                        cur_nxt.phase = st_wdat;
                     end else begin
                        cur_nxt.phase = st_idle;
                     end
                  end
                  st_wdat : begin
                     if (!cur_r.lock[lock_cfg_bit] || cur_r.ptr == reg_lock_off) begin
                        if (cur_r.ptr == reg_user_id_off) begin
                           cur_nxt.uid = cur_r.shift;
                        end
                        if (cur_r.ptr == reg_lock_off) begin
                           cur_nxt.lock = cur_r.lock ^ cur_r.shift[1:0];
                        end
                     end
                  end
                  default : ;
               endcase
               if (cur_nxt.phase == st_rdat) begin
                  cur_nxt.shift = read_reg(cur_r.ptr, cur_r.uid, cur_r.lock);
                  cur_nxt.drive_low = !cur_nxt.shift[7];
               end
            end else if (cur_r.phase == st_rdat) begin
               // The shift register has just taken in the bit on the line, so its top bit goes out next.
               cur_nxt.drive_low = !cur_r.shift[7];
            end
         end
      end
      if (cur_r.phase == st_rdat && scl_fall && cur_r.bitn == bits_per_word - 4'h1) begin
         cur_nxt.drive_low = 1'b0;
      end
      // A fault log sets its flag last, so that it wins over a lock write in the same cycle.
      if (fault_logged) begin
         cur_nxt.lock[lock_fault_bit] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, strap: strap_gnd, phase: st_idle,
                    bitn: 4'h0, shift: 8'h00, ack: 1'b0, rd: 1'b0, ptr: 8'h00, uid: user_id_reset,
                    strap_m: strap_gnd, lock: lock_reset, busy: 1'b0, drive_low: 1'b0};
      end else if (ce) begin
         cur_r <= cur_nxt;
      end
   end

   assign link.sda_s_o  = 1'b0;
   assign link.sda_s_oe = cur_r.drive_low;
   assign bus_busy      = cur_r.busy;
   assign user_id       = cur_r.uid;
   assign lock_flags    = cur_r.lock;
endmodule : twi_cfg_slave
`default_nettype wire

// ### hdl/twi_cfg_pkg.sv
// Shared constants for the two-wire configuration port and its master.
package twi_cfg_pkg;
   localparam logic [7:0] reg_user_id_off    = 8'h5C;
   localparam logic [7:0] reg_lock_off       = 8'h5D;
   localparam logic [7:0] reg_revision_off   = 8'h65;
   localparam logic [7:0] user_id_reset      = 8'h00;
   localparam logic [1:0] lock_reset         = 2'h0;
   localparam logic [2:0] revision_code      = 3'h1; // Arbitrary value.
   localparam int         lock_cfg_bit       = 0;
   localparam int         lock_fault_bit     = 1;
   localparam logic [7:0] fault_prot_last    = 8'h11;
   localparam logic [3:0] addr_upper         = 4'hA;
   localparam logic [1:0] strap_gnd          = 2'h0;
   localparam logic [1:0] strap_supply       = 2'h1;
   localparam logic [1:0] strap_clk          = 2'h2;
   localparam logic [1:0] strap_data         = 2'h3;
   localparam int         bus_rate_khz       = 400;
   localparam int         sys_clk_khz        = 25000;
   localparam int         half_bit_cycles    = sys_clk_khz / (2 * bus_rate_khz) + 1;
   localparam logic [3:0] bits_per_word      = 4'h8;
   localparam logic [3:0] cmd_off            = 4'h0;
   localparam logic [3:0] cmd_ctl            = 4'h1;
   localparam logic [3:0] cmd_stat           = 4'h2;
   localparam logic [3:0] cmd_rdata          = 4'h3;
endpackage : twi_cfg_pkg

// ### hdl/twi_link_if.sv
// Two-wire link between the configuration slave and its bus master.
`timescale 1ns/1ps
`default_nettype none
interface twi_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   wire  scl_line = !(scl_oe && !scl_o);
   wire  sda_line = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
   modport slave  (input scl_line, input sda_line, output sda_s_o, output sda_s_oe);
   modport master (input scl_line, input sda_line, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface : twi_link_if
`default_nettype wire

// ### hdl/twi_cfg_master.sv
// Two-wire bus master that writes or reads one slave register on command.
`timescale 1ns/1ps
`default_nettype none
module twi_cfg_master
   import twi_cfg_pkg::*;
(
   // Clock, reset, enable.
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Link.
   twi_link_if.master      link,
   // Register port.
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata
);
   import twi_cfg_pkg::*;

   typedef enum logic [5:0] {
      m_idle = 6'b000001, m_start = 6'b000010, m_bit = 6'b000100,
      m_rstart = 6'b001000, m_stop = 6'b010000, m_done = 6'b100000
   } mstate_e;

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      mstate_e    st;
      logic [7:0] div;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [1:0] word;
      logic [8:0] sh;
      logic       sda_out;
      logic       scl_out;
      logic [7:0] off;
      logic [7:0] wd;
      logic [6:0] saddr;
      logic       is_rd;
      logic       nack;
      logic [7:0] rbyte;
      logic [7:0] rdata;
   } mst_s;

   mst_s m_r, m_nxt;
   logic tick;
   assign tick = m_r.div == 8'(half_bit_cycles - 1);

   function automatic logic [8:0] frame(input logic [7:0] b, input logic last_rd);
      frame = {b, last_rd}; // Ninth bit: 1 releases the line for the slave or sends NACK.
   endfunction : frame

   always_comb begin
      m_nxt = m_r;
      m_nxt.scl_s = {m_r.scl_s[0], link.scl_line};
      m_nxt.sda_s = {m_r.sda_s[0], link.sda_line};
      m_nxt.div = tick ? 8'h00 : m_r.div + 8'h01;
      if (wr && m_r.st == m_idle) begin
         unique case (addr)
            cmd_off : m_nxt.off = wdata;
            cmd_ctl : begin
               m_nxt.saddr = wdata[6:0];
               m_nxt.is_rd = wdata[7];
               m_nxt.st = m_start;
               m_nxt.ph = 2'h0;
               m_nxt.word = 2'h0;
            end
            default : m_nxt.wd = wdata;
         endcase
      end
      if (rd) begin
         unique case (addr)
            // Busy lasts until the master is idle, since a new command is refused before then.
            cmd_stat  : m_nxt.rdata = {6'h00, m_r.nack, m_r.st != m_idle};
            cmd_rdata : m_nxt.rdata = m_r.rbyte;
            default   : m_nxt.rdata = m_r.off;
         endcase
      end
      if (tick) begin
         m_nxt.ph = m_r.ph + 2'h1;
         unique case (m_r.st)
            m_start, m_rstart : begin
               unique case (m_r.ph)
                  2'h0 : begin m_nxt.sda_out = 1'b1; m_nxt.scl_out = 1'b1; end
                  2'h1 : m_nxt.sda_out = 1'b0;
                  2'h2 : begin
                     m_nxt.scl_out = 1'b0;
                     m_nxt.st = m_bit;
                     m_nxt.ph = 2'h0;
                     m_nxt.bitn = 4'h0;
                     m_nxt.sh = frame({m_r.saddr, m_r.st == m_rstart}, 1'b1);
                  end
                  default : ;
               endcase
            end
            m_bit : begin
               unique case (m_r.ph)
                  2'h0 : m_nxt.sda_out = m_r.sh[8];
                  2'h1 : m_nxt.scl_out = 1'b1;
                  2'h2 : begin
                     m_nxt.sh = {m_r.sh[7:0], m_r.scl_s[1] ? m_r.sda_s[1] : 1'b1};
                     if (m_r.bitn == bits_per_word && m_r.sda_s[1] && !(m_r.is_rd && m_r.word == 2'h3))
                        m_nxt.nack = 1'b1;
                  end
                  default : begin
                     m_nxt.scl_out = 1'b0;
                     m_nxt.ph = 2'h0;
                     m_nxt.bitn = m_r.bitn + 4'h1;
                     if (m_r.bitn == bits_per_word) begin
                        m_nxt.bitn = 4'h0;
                        m_nxt.word = m_r.word + 2'h1;
                        // A read carries a fourth word: the address again after the repeated start, then the data.
                        if (m_r.is_rd && m_r.word == 2'h3) m_nxt.rbyte = m_r.sh[8:1];
                        if (m_nxt.nack || m_r.word == (m_r.is_rd ? 2'h3 : 2'h2)) m_nxt.st = m_stop;
                        else if (m_r.word == 2'h1 && m_r.is_rd) m_nxt.st = m_rstart;
                        m_nxt.sh = frame(m_r.word == 2'h0 ? m_r.off : m_r.is_rd ? 8'hFF : m_r.wd, 1'b1);
                        m_nxt.sda_out = 1'b1;
                     end else if (m_r.is_rd && m_r.word == 2'h3 && m_r.bitn == bits_per_word - 4'h1) begin
                        m_nxt.sh[8] = 1'b1;
                     end
                  end
               endcase
               if (m_r.ph == 2'h0 && m_r.st == m_bit && m_r.bitn == 4'h0 && m_r.word == 2'h1 && m_r.is_rd)
                  m_nxt.sda_out = m_r.sh[8];
            end
            m_stop : begin
               unique case (m_r.ph)
                  2'h0 : m_nxt.sda_out = 1'b0;
                  2'h1 : m_nxt.scl_out = 1'b1;
                  default : begin
                     m_nxt.sda_out = 1'b1;
                     m_nxt.st = m_done;
                  end
               endcase
            end
            default : m_nxt.ph = 2'h0;
         endcase
         if (m_r.st == m_done) m_nxt.st = m_idle;
      end
      if (wr && addr == cmd_ctl && m_r.st == m_idle) m_nxt.nack = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         m_r <= '{scl_s: 2'h3, sda_s: 2'h3, st: m_idle, div: 8'h00, ph: 2'h0, bitn: 4'h0, word: 2'h0,
                  sh: 9'h1FF, sda_out: 1'b1, scl_out: 1'b1, off: 8'h00, wd: 8'h00, saddr: 7'h00,
                  is_rd: 1'b0, nack: 1'b0, rbyte: 8'h00, rdata: 8'h00};
      end else if (ce) begin
         m_r <= m_nxt;
      end
   end

   assign link.scl_o    = 1'b0;
   assign link.scl_oe   = !m_r.scl_out;
   assign link.sda_m_o  = 1'b0;
   assign link.sda_m_oe = !m_r.sda_out;
   assign rdata         = m_r.rdata;
endmodule : twi_cfg_master
`default_nettype wire

// ### dv/twi_cfg_checker.sv
// Protocol assertions on the two-wire link between the configuration master and slave.
`timescale 1ns/1ps
`default_nettype none
module twi_cfg_checker (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Link lines and slave drive.
   input wire logic scl_line,
   input wire logic sda_line,
   input wire logic sda_s_o,
   input wire logic sda_s_oe,
   // Slave status.
   input wire logic bus_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic       scl_q;
   logic       sda_q;
   logic [7:0] per_cnt;
   logic [3:0] bit_cnt;
   wire        rise    = scl_line && !scl_q;
   wire        start_c = scl_line && scl_q && sda_q && !sda_line;
   wire        stop_c  = scl_line && scl_q && !sda_q && sda_line;

   // Bit slots are counted from each start so that the ninth slot can be singled out.
   always_ff @(posedge clk) begin
      scl_q   <= rst ? 1'b1 : scl_line;
      sda_q   <= rst ? 1'b1 : sda_line;
      per_cnt <= rst ? 8'hFF : rise ? 8'h01 : (per_cnt == 8'hFF) ? per_cnt : per_cnt + 8'h01;
      bit_cnt <= (rst || start_c) ? 4'h0 : !rise ? bit_cnt : (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
   end

   property p_open_drain;
      sda_s_oe |-> !sda_s_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("slave drives data high");
   property p_start_busy;
      start_c |-> ##[1:8] bus_busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start not seen");
   property p_stop_free;
      stop_c |-> ##[1:8] !bus_busy;
   endproperty
   a_stop_free: assert property (p_stop_free) else $error("stop did not free bus");
   property p_quiet;
      !bus_busy |-> !sda_s_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("slave drives idle bus");
   property p_stable;
      scl_line && scl_q |-> $stable(sda_s_oe);
   endproperty
   a_stable: assert property (p_stable) else $error("slave data moved while clock high");
   property p_ack_hold;
      rise && sda_s_oe && bit_cnt == 4'h8 |-> !sda_line [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not held");
   property p_rate;
      rise |-> per_cnt >= 8'd63;
   endproperty
   a_rate: assert property (p_rate) else $error("link clock too fast");
   // A stop falls in the clock high pulse that follows a complete word and its acknowledge.
   property p_words;
      stop_c |-> bit_cnt == 4'h1;
   endproperty
   a_words: assert property (p_words) else $error("stop inside a word");

   c_start: cover property (start_c);
   c_ack: cover property (rise && bit_cnt == 4'h8 && !sda_line);
   c_stop: cover property (stop_c);
endmodule : twi_cfg_checker
`default_nettype wire

// ### dv/two_wire_slave_config_port_test.sv
// Self-checking bench for the two-wire configuration slave driven by its master.
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_config_port_test;
   import twi_cfg_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       ce = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic [1:0] strap = 2'h0;
   logic       reboot_busy = 1'b0;
   logic       eeprom_busy = 1'b0;
   logic       fault_logged = 1'b0;
   logic       bus_busy;
   logic [7:0] user_id;
   logic [1:0] lock_flags;
   logic [7:0] st;
   logic [7:0] rb;
   int         fail_count = 0;
   int         num_checks = 0;
   int         cyc = 0;

   twi_link_if link ();
   twi_cfg_slave u_twi_cfg_slave (.clk(clk), .rst(rst), .ce(ce), .link(link.slave), .address_strap_pin(strap),
      .reboot_busy(reboot_busy), .eeprom_busy(eeprom_busy), .fault_logged(fault_logged), .bus_busy(bus_busy),
      .user_id(user_id), .lock_flags(lock_flags));
   twi_cfg_master u_twi_cfg_master (.clk(clk), .rst(rst), .ce(ce), .link(link.master), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   twi_cfg_checker chk (.clk(clk), .rst(rst), .scl_line(link.scl_line), .sda_line(link.sda_line),
      .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .bus_busy(bus_busy));

   always #20 clk = ~clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("Mismatches %0d in %0d checks", fail_count, num_checks);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   // A hang on the link is cut short well after the longest expected run.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rreg

   // One whole master transfer; status lands in st and the read byte in rb.
   task automatic xfer(input logic [6:0] sa, input logic rw, input logic [7:0] off, input logic [7:0] d);
      int n;
      wreg(4'h0, off);
      wreg(4'h2, d);
      wreg(4'h1, {rw, sa});
      n = 0;
      rreg(4'h2, st);
      while (st[0] !== 1'b0 && n < 12000) begin
         rreg(4'h2, st);
         n++;
      end
      rreg(4'h3, rb);
   endtask : xfer

   function automatic logic [6:0] saddr(input logic [1:0] s, input logic x);
      return {4'hA, s, x};
   endfunction : saddr

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check(user_id, user_id_reset);
      check({6'h0, lock_flags}, {6'h0, lock_reset});
      check({6'h0, bus_busy, link.sda_line & link.scl_line}, 8'h01);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         strap <= s[1:0];
         xfer(saddr(s[1:0], s[0]), 1'b0, reg_user_id_off, 8'hA0 + 8'(s));
         check(st & 8'h03, 8'h00);
         check(user_id, 8'hA0 + 8'(s));
      end
      xfer(saddr(2'h2, 1'b0), 1'b0, reg_user_id_off, 8'h55);
      check(st & 8'h03, 8'h02);
      check(user_id, 8'hA3);
      xfer(saddr(2'h3, 1'b0), 1'b1, reg_user_id_off, 8'h00);
      check(st & 8'h03, 8'h00);
      check(rb, 8'hA3);
      xfer(saddr(2'h3, 1'b0), 1'b0, reg_revision_off, 8'hFF);
      xfer(saddr(2'h3, 1'b0), 1'b1, reg_revision_off, 8'h00);
      check(rb, {5'h00, revision_code});
      xfer(saddr(2'h3, 1'b0), 1'b0, reg_lock_off, 8'hFD);
      check({6'h0, lock_flags}, 8'h01);
      xfer(saddr(2'h3, 1'b0), 1'b0, reg_user_id_off, 8'h3C);
      check(st & 8'h03, 8'h00);
      check(user_id, 8'hA3);
      xfer(saddr(2'h3, 1'b0), 1'b1, reg_lock_off, 8'h00);
      check(rb, 8'h01);
      xfer(saddr(2'h3, 1'b0), 1'b0, reg_lock_off, 8'h01);
      check({6'h0, lock_flags}, 8'h00);
      @(posedge clk);
      fault_logged <= 1'b1;
      @(posedge clk);
      fault_logged <= 1'b0;
      repeat (4) @(posedge clk);
      check({6'h0, lock_flags}, 8'h02);
      xfer(saddr(2'h3, 1'b0), 1'b0, reg_user_id_off, 8'h77);
      check(user_id, 8'h77);
      xfer(saddr(2'h3, 1'b0), 1'b0, 8'h10, 8'h00);
      check(st & 8'h03, 8'h02);
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         reboot_busy <= (b == 0);
         eeprom_busy <= (b == 1);
         xfer(saddr(2'h3, 1'b0), 1'b0, reg_user_id_off, 8'h11);
         check(st & 8'h03, 8'h02);
         check(user_id, 8'h77);
      end
      close_out();
   end
endmodule : two_wire_slave_config_port_test
`default_nettype wire
